// file: rsl_strap_latch.sv
// reset mode strap latch: mode and flash visibility capture, security gating
`timescale 1ns/1ps
`include "rsl_params.svh"

module rsl_strap_latch #(
    parameter int MODE_W = `RSL_MODE_W
) (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              mode_strap_bit2_i,
    input  wire logic              mode_strap_bit1_i,
    input  wire logic              mode_strap_bit0_i,
    input  wire logic              flash_visible_strap_i,
    input  wire logic              nv_secured_i,
    input  wire logic              mode_wr_i,
    input  wire logic [MODE_W-1:0] mode_wr_data_i,
    input  wire logic              debug_activate_i,
    output logic      [MODE_W-1:0] mode_o,
    output logic                   flash_visible_bit_o,
    output logic                   flash_in_map_o,
    output logic                   bus_expanded_o,
    output logic                   bus_wide_o,
    output logic                   special_mode_o,
    output logic                   background_debug_allowed_o,
    output logic                   background_debug_active_o,
    output logic                   secured_o,
    output logic                   ext_access_block_o,
    output logic                   peripheral_mode_o,
    output logic                   mode_wr_refused_o
);

    if (MODE_W != `RSL_MODE_W) begin : g_bad_width
        $error("mode width must be 3");
    end

    rsl_pkg::rsl_state_t st_r;
    rsl_pkg::rsl_state_t st_nxt;

    logic [2:0] strap_mode;
    logic       strap_flash;
    logic       strap_dbg;
    logic       capture;
    logic       cur_flash_unused;
    logic       cur_expanded;
    logic       cur_wide;
    logic       cur_special;
    logic       cur_dbg_unused;
    logic       cur_periph;

    assign strap_mode = {mode_strap_bit2_i, mode_strap_bit1_i, mode_strap_bit0_i};
    assign capture    = (st_r.phase == rsl_pkg::RSL_PH_RESET) && !reset_i;

    // special modes may move to any usable mode; normal single chip may only expand
    function automatic logic wr_allowed(input logic [2:0] cur, input logic [2:0] tgt);
        logic ok;
        ok = 1'b0;
        if (tgt == `RSL_MODE_PERIPH) begin
            ok = 1'b0;
        end else if (!cur[`RSL_MODE_NORMAL_BIT]) begin
            ok = 1'b1;
        end else if (cur == `RSL_MODE_NSC) begin
            ok = (tgt == `RSL_MODE_NRM_NARROW) || (tgt == `RSL_MODE_NRM_WIDE);
        end
        return ok;
    endfunction

    // debug is refused while secured, except in special single chip for unsecuring
    function automatic logic dbg_allowed(input logic [2:0] cur, input logic sec);
        return !sec || (cur == `RSL_MODE_SSC);
    endfunction

    rsl_mode_decode u_strap_dec (
        .mode_i          (strap_mode),
        .flash_strap_i   (flash_visible_strap_i),
        .flash_visible_o (strap_flash),
        .expanded_o      (),
        .wide_o          (),
        .special_o       (),
        .debug_active_o  (strap_dbg),
        .peripheral_o    ()
    );

    rsl_mode_decode u_cur_dec (
        .mode_i          (st_r.mode),
        .flash_strap_i   (1'b0),
        .flash_visible_o (cur_flash_unused),
        .expanded_o      (cur_expanded),
        .wide_o          (cur_wide),
        .special_o       (cur_special),
        .debug_active_o  (cur_dbg_unused),
        .peripheral_o    (cur_periph)
    );

    always_comb begin
        st_nxt            = st_r;
        st_nxt.wr_refused = 1'b0;
        if (reset_i) begin
            st_nxt.phase      = rsl_pkg::RSL_PH_RESET;
            st_nxt.mode       = `RSL_MODE_RST;
            st_nxt.flash_vis  = `RSL_FLASH_VIS_RST;
            st_nxt.dbg_active = `RSL_DEBUG_ACT_RST;
            st_nxt.secured    = `RSL_SECURED_RST;
        end else begin
            case (st_r.phase)
                rsl_pkg::RSL_PH_RESET: begin
                    st_nxt.phase      = rsl_pkg::RSL_PH_RUN;
                    st_nxt.mode       = strap_mode;
                    st_nxt.flash_vis  = strap_flash;
                    st_nxt.secured    = nv_secured_i;
                    st_nxt.dbg_active = strap_dbg && dbg_allowed(strap_mode, nv_secured_i);
                end
                rsl_pkg::RSL_PH_RUN: begin
                    if (mode_wr_i) begin
                        if (wr_allowed(st_r.mode, mode_wr_data_i)) begin
                            st_nxt.mode = mode_wr_data_i;
                        end else begin
                            st_nxt.wr_refused = 1'b1;
                        end
                    end
                    if (debug_activate_i && dbg_allowed(st_r.mode, st_r.secured)) begin
                        st_nxt.dbg_active = 1'b1;
                    end
                end
                default: begin
                    st_nxt.phase = rsl_pkg::RSL_PH_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    assign mode_o                     = st_r.mode;
    assign flash_visible_bit_o        = st_r.flash_vis;
    assign flash_in_map_o             = st_r.flash_vis && !(st_r.secured && cur_expanded);
    assign bus_expanded_o             = cur_expanded;
    assign bus_wide_o                 = cur_wide;
    assign special_mode_o             = cur_special;
    assign background_debug_allowed_o = dbg_allowed(st_r.mode, st_r.secured);
    assign background_debug_active_o  = st_r.dbg_active;
    assign secured_o                  = st_r.secured;
    assign ext_access_block_o         = st_r.secured;
    assign peripheral_mode_o          = cur_periph;
    assign mode_wr_refused_o          = st_r.wr_refused;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_mode_capture:
    assert property (capture |=> mode_o == $past(strap_mode))
        else $error("mode bits differ from straps at release");

    a_flash_fixed:
    assert property (capture && strap_mode == `RSL_MODE_NSC |=> flash_visible_bit_o)
        else $error("normal single chip flash not visible");

    a_flash_invert:
    assert property (capture && strap_mode == `RSL_MODE_EMU_NARROW
                     |=> flash_visible_bit_o == !$past(flash_visible_strap_i))
        else $error("emulation narrow flash bit not inverted strap");

    a_test_flash_off:
    assert property (capture && strap_mode == `RSL_MODE_SPEC_TEST |=> !flash_visible_bit_o ##0 bus_wide_o)
        else $error("special test flash visible or bus not wide");

    a_ssc_debug_on:
    assert property (capture && strap_mode == `RSL_MODE_SSC |=> background_debug_active_o && flash_visible_bit_o)
        else $error("special single chip debug inactive");

    a_debug_idle:
    assert property (capture && strap_mode != `RSL_MODE_SSC |=> !background_debug_active_o)
        else $error("debug active without command");

    a_secure_map:
    assert property (secured_o && bus_expanded_o |-> !flash_in_map_o)
        else $error("flash mapped while secured and expanded");

    a_secure_debug:
    assert property (secured_o && mode_o == `RSL_MODE_NSC && !background_debug_active_o
                     |=> !background_debug_active_o)
        else $error("secured device activated debug");

    a_resecure:
    assert property (capture && nv_secured_i |=> secured_o && ext_access_block_o)
        else $error("reset did not re-secure");

    a_mode_steady:
    assert property (!capture && !mode_wr_i |=> $stable(mode_o) && $stable(flash_visible_bit_o))
        else $error("mode or flash bit changed without write");

    a_periph_refused:
    assert property (!capture && mode_wr_i && mode_wr_data_i == `RSL_MODE_PERIPH |=> mode_wr_refused_o)
        else $error("peripheral mode write accepted");

    a_nsc_expand:
    assert property (!capture && mode_o == `RSL_MODE_NSC && mode_wr_i && mode_wr_data_i == `RSL_MODE_NRM_NARROW
                     |=> mode_o == `RSL_MODE_NRM_NARROW && bus_expanded_o && !mode_wr_refused_o)
        else $error("normal single chip could not expand");

    a_flash_follow:
    assert property (capture && (strap_mode == `RSL_MODE_NRM_NARROW || strap_mode == `RSL_MODE_NRM_WIDE)
                     |=> flash_visible_bit_o == $past(flash_visible_strap_i))
        else $error("normal expanded flash bit differs from strap");

endmodule

// file: rsl_params.svh
// constants for the reset mode strap latch
`ifndef RSL_PARAMS_SVH
`define RSL_PARAMS_SVH

`define RSL_MODE_W          3
`define RSL_MODE_SSC        3'h0
`define RSL_MODE_EMU_NARROW 3'h1
`define RSL_MODE_SPEC_TEST  3'h2
`define RSL_MODE_EMU_WIDE   3'h3
`define RSL_MODE_NSC        3'h4
`define RSL_MODE_NRM_NARROW 3'h5
`define RSL_MODE_PERIPH     3'h6
`define RSL_MODE_NRM_WIDE   3'h7
`define RSL_MODE_NORMAL_BIT 2
`define RSL_MODE_RST        3'h0
`define RSL_FLASH_VIS_RST   1'h1
`define RSL_DEBUG_ACT_RST   1'h0
`define RSL_SECURED_RST     1'h1

`endif

// file: rsl_pkg.sv
// types for the reset mode strap latch
package rsl_pkg;

    typedef enum logic [0:0] {
        RSL_PH_RESET,
        RSL_PH_RUN
    } rsl_phase_t;

    typedef struct packed {
        rsl_phase_t  phase;
        logic [2:0]  mode;
        logic        flash_vis;
        logic        dbg_active;
        logic        secured;
        logic        wr_refused;
    } rsl_state_t;

endpackage

// file: rsl_mode_decode.sv
// decode of one mode pattern into memory map and bus configuration
`timescale 1ns/1ps
`include "rsl_params.svh"

module rsl_mode_decode (
    input  wire logic [2:0] mode_i,
    input  wire logic       flash_strap_i,
    output logic            flash_visible_o,
    output logic            expanded_o,
    output logic            wide_o,
    output logic            special_o,
    output logic            debug_active_o,
    output logic            peripheral_o
);

    always_comb begin
        flash_visible_o = 1'b1;
        expanded_o      = 1'b0;
        wide_o          = 1'b0;
        debug_active_o  = 1'b0;
        peripheral_o    = 1'b0;
        special_o       = ~mode_i[`RSL_MODE_NORMAL_BIT];
        case (mode_i)
            `RSL_MODE_SSC: begin
                flash_visible_o = 1'b1;
                debug_active_o  = 1'b1;
            end
            `RSL_MODE_EMU_NARROW: begin
                flash_visible_o = ~flash_strap_i;
                expanded_o      = 1'b1;
            end
            `RSL_MODE_SPEC_TEST: begin
                flash_visible_o = 1'b0;
                expanded_o      = 1'b1;
                wide_o          = 1'b1;
            end
            `RSL_MODE_EMU_WIDE: begin
                flash_visible_o = ~flash_strap_i;
                expanded_o      = 1'b1;
                wide_o          = 1'b1;
            end
            `RSL_MODE_NSC: begin
                flash_visible_o = 1'b1;
            end
            `RSL_MODE_NRM_NARROW: begin
                flash_visible_o = flash_strap_i;
                expanded_o      = 1'b1;
            end
            `RSL_MODE_PERIPH: begin
                flash_visible_o = 1'b1;
                peripheral_o    = 1'b1;
            end
            `RSL_MODE_NRM_WIDE: begin
                flash_visible_o = flash_strap_i;
                expanded_o      = 1'b1;
                wide_o          = 1'b1;
            end
            default: begin
                flash_visible_o = 1'b1;
            end
        endcase
    end

endmodule

// file: rsl_board_model.sv
// board side model: reset driver and strap pins
`timescale 1ns/1ps
`include "rsl_params.svh"

module rsl_board_model (
    input  wire logic       clk_i,
    output logic            reset_o,
    output logic [2:0]      mode_strap_o,
    output logic            flash_strap_o
);
    initial begin
        reset_o       = 1'h1;
        mode_strap_o  = 3'h0;
        flash_strap_o = 1'h0;
    end

    // reset pulse, straps valid at release, then straps flip to show they are ignored
    task automatic boot(input logic [2:0] pat, input logic fs);
        @(posedge clk_i);
        #1;
        reset_o = 1'h1;
        repeat (2) @(posedge clk_i);
        #1;
        reset_o       = 1'h0;
        mode_strap_o  = (pat == `RSL_MODE_PERIPH) ? `RSL_MODE_NRM_WIDE : pat;
        flash_strap_o = fs;
        @(posedge clk_i);
        #1;
        mode_strap_o  = ~pat;
        flash_strap_o = ~fs;
    endtask
endmodule

// file: rsl_strap_latch_tb_top.sv
// self-checking testbench for the reset mode strap latch
`timescale 1ns/1ps
`include "rsl_params.svh"

module rsl_strap_latch_tb_top;
    logic       clk_i = 1'h0;
    logic       reset_i;
    logic [2:0] strap;
    logic       fstrap;
    logic       nv_sec = 1'h0;
    logic       wr = 1'h0;
    logic [2:0] wr_data = 3'h0;
    logic       dbg_act = 1'h0;
    logic [2:0] mode;
    logic       fv, in_map, expd, wide, spec, dbg_ok, dbg_on, sec, blk, per, refused;
    int         fails = 0;
    int         tests_run = 0;

    always #50 clk_i = ~clk_i;

    rsl_board_model board (.clk_i(clk_i), .reset_o(reset_i), .mode_strap_o(strap), .flash_strap_o(fstrap));

    rsl_strap_latch dut (
        .clk_i(clk_i), .reset_i(reset_i), .mode_strap_bit2_i(strap[2]), .mode_strap_bit1_i(strap[1]),
        .mode_strap_bit0_i(strap[0]), .flash_visible_strap_i(fstrap), .nv_secured_i(nv_sec),
        .mode_wr_i(wr), .mode_wr_data_i(wr_data), .debug_activate_i(dbg_act), .mode_o(mode),
        .flash_visible_bit_o(fv), .flash_in_map_o(in_map), .bus_expanded_o(expd), .bus_wide_o(wide),
        .special_mode_o(spec), .background_debug_allowed_o(dbg_ok), .background_debug_active_o(dbg_on),
        .secured_o(sec), .ext_access_block_o(blk), .peripheral_mode_o(per), .mode_wr_refused_o(refused)
    );

    task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic exp_fv(input logic [2:0] p, input logic s);
        case (p)
            3'h0, 3'h4, 3'h6: exp_fv = 1'h1;
            3'h2:             exp_fv = 1'h0;
            3'h1, 3'h3:       exp_fv = ~s;
            default:          exp_fv = s;
        endcase
    endfunction

    task automatic pulse_wr(input logic [2:0] d);
        @(posedge clk_i);
        #1;
        wr      = 1'h1;
        wr_data = d;
        @(posedge clk_i);
        #1;
        wr = 1'h0;
    endtask

    task automatic pulse_dbg();
        dbg_act = 1'h1;
        @(posedge clk_i);
        #1;
        dbg_act = 1'h0;
    endtask

    task automatic t_straps();
        logic [2:0] p;
        nv_sec = 1'h0;
        for (int i = 0; i < 16; i++) begin
            p = i[3:1];
            if (p != `RSL_MODE_PERIPH) begin
                board.boot(p, i[0]);
                chk("mode", p, mode);
                chk("flash_vis", {2'h0, exp_fv(p, i[0])}, {2'h0, fv});
                chk("in_map", {2'h0, exp_fv(p, i[0])}, {2'h0, in_map});
                chk("expanded", {2'h0, p[1] | p[0]}, {2'h0, expd});
                chk("wide", {2'h0, p[1]}, {2'h0, wide});
                chk("special", {2'h0, ~p[2]}, {2'h0, spec});
                chk("dbg_active", {2'h0, p == 3'h0}, {2'h0, dbg_on});
                chk("dbg_allowed", 3'h1, {2'h0, dbg_ok});
                chk("peripheral", 3'h0, {2'h0, per});
                @(posedge clk_i);
                #1;
                chk("mode_hold", p, mode);
            end
        end
        $display("test straps done");
    endtask

    task automatic t_mode_wr();
        board.boot(`RSL_MODE_NSC, 1'h0);
        pulse_wr(`RSL_MODE_PERIPH);
        chk("refused", 3'h1, {2'h0, refused});
        chk("mode", `RSL_MODE_NSC, mode);
        chk("peripheral", 3'h0, {2'h0, per});
        pulse_wr(`RSL_MODE_NRM_NARROW);
        chk("refused", 3'h0, {2'h0, refused});
        chk("mode", `RSL_MODE_NRM_NARROW, mode);
        chk("expanded", 3'h1, {2'h0, expd});
        pulse_wr(`RSL_MODE_NSC);
        chk("mode", `RSL_MODE_NRM_NARROW, mode);
        chk("flash_vis", 3'h1, {2'h0, fv});
        board.boot(`RSL_MODE_SSC, 1'h0);
        pulse_wr(`RSL_MODE_EMU_WIDE);
        chk("mode", `RSL_MODE_EMU_WIDE, mode);
        $display("test mode write done");
    endtask

    task automatic t_secure();
        nv_sec = 1'h0;
        board.boot(`RSL_MODE_NSC, 1'h0);
        pulse_dbg();
        chk("dbg_active", 3'h1, {2'h0, dbg_on});
        nv_sec = 1'h1;
        board.boot(`RSL_MODE_NSC, 1'h0);
        chk("secured", 3'h1, {2'h0, sec});
        chk("dbg_allowed", 3'h0, {2'h0, dbg_ok});
        pulse_dbg();
        chk("dbg_active", 3'h0, {2'h0, dbg_on});
        chk("in_map", 3'h1, {2'h0, in_map});
        board.boot(`RSL_MODE_NRM_NARROW, 1'h1);
        chk("in_map", 3'h0, {2'h0, in_map});
        chk("ext_block", 3'h1, {2'h0, blk});
        board.boot(`RSL_MODE_SSC, 1'h0);
        chk("dbg_active", 3'h1, {2'h0, dbg_on});
        $display("test security done");
    endtask

    task automatic end_of_test();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (1) @(posedge clk_i);
        t_straps();
        t_mode_wr();
        t_secure();
        end_of_test();
    end

    initial begin
        #(100 * 2000);
        fails++;
        end_of_test();
    end
endmodule
